// file: src/epiu_top.sv
// external pin and pin-change interrupt unit with apb register slave
`timescale 1ns/10ps
`default_nettype none
module epiu_top
   import epiu_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic [23:0] pin_change_inputs,
   // processor side
   input wire logic [4:0] irqAck,
   output logic [4:0] irqReq,
   output logic wakeReq
);
   // ****************************************
   // state
   // ****************************************
   epiu_state_t cur;
   epiu_state_t next_cur;

   logic stopped;
   logic [NUM_EXT-1:0] extEvent;
   logic [NUM_EXT-1:0] levelLow;
   logic [NUM_EXT-1:0] flagSeen;
   logic [NUM_GRP-1:0] pcEvent;
   logic [23:0] pinMask;
   logic [23:0] pcChg;

   assign stopped = cur.sleep;
   assign pinMask = {cur.mask2, cur.mask1, cur.mask0};
   // pins are read whatever their direction, so software can drive them
   assign pcChg = cur.syncB[NUM_PINS-1:NUM_EXT] ^ cur.last[NUM_PINS-1:NUM_EXT];

   // ****************************************
   // event detection
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_GRP; gi++) begin : g_grp
         // not gated by sleep: stands in for the clockless path
         assign pcEvent[gi] = |(pcChg[gi*8 +: 8] & pinMask[gi*8 +: 8]);
      end
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
         logic [1:0] mode;
         logic rise;
         logic fall;
         assign mode = cur.sense[gi*2 +: 2];
         assign rise = cur.syncB[gi] & ~cur.last[gi];
         assign fall = ~cur.syncB[gi] & cur.last[gi];
         assign levelLow[gi] = (mode == SENSE_LOW) & ~cur.syncB[gi];
         // a flag left from an edge mode must not read back or request
         assign flagSeen[gi] = cur.extFlag[gi] & (mode != SENSE_LOW);
         // edge logic runs only while the io clock runs
         assign extEvent[gi] = ~stopped & ((mode == SENSE_ANY & (rise | fall))
                               | (mode == SENSE_FALL & fall)
                               | (mode == SENSE_RISE & rise));
      end
   endgenerate

   // ****************************************
   // register decode
   // ****************************************
   logic [9:0] idx;
   logic hit;
   logic [7:0] rdByte;
   logic wrEn;
   logic w1c;
   assign idx = paddr[11:2];
   assign wrEn = psel & penable & pwrite & cur.pready & pstrb[0];
   assign w1c = wrEn;

   always_comb begin
      hit = 1'b1;
      rdByte = REG_RESET;
      if (idx == IDX_PC_FLAGS) begin
         rdByte = {5'h00, cur.pcFlag};
      end else if (idx == IDX_EXT_FLAGS) begin
         rdByte = {6'h00, flagSeen};
      end else if (idx == IDX_EXT_EN) begin
         rdByte = {6'h00, cur.extEn};
      end else if (idx == IDX_PC_EN) begin
         rdByte = {5'h00, cur.pcEn};
      end else if (idx == IDX_SENSE) begin
         rdByte = {4'h0, cur.sense};
      end else if (idx == IDX_MASK0) begin
         rdByte = cur.mask0;
      end else if (idx == IDX_MASK1) begin
         rdByte = cur.mask1;
      end else if (idx == IDX_MASK2) begin
         rdByte = cur.mask2;
      end else if (idx == IDX_CTRL) begin
         rdByte = {6'h00, cur.sleep, cur.gie};
      end else begin
         hit = 1'b0;
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_cur = cur;
      next_cur.syncA = {pin_change_inputs, ext_irq_pin_one, ext_irq_pin_zero};
      next_cur.syncB = cur.syncA;
      next_cur.last = cur.syncB;
      // answer one cycle after setup: data and error captured at setup
      next_cur.pready = psel & ~penable;
      if (psel & ~penable) begin
         next_cur.prdata = {24'h000000, rdByte};
         next_cur.pslverr = ~hit;
      end
      if (wrEn & hit) begin
         if (idx == IDX_EXT_EN) begin
            next_cur.extEn = pwdata[1:0];
         end else if (idx == IDX_PC_EN) begin
            next_cur.pcEn = pwdata[2:0];
         end else if (idx == IDX_SENSE) begin
            next_cur.sense = pwdata[3:0];
         end else if (idx == IDX_MASK0) begin
            next_cur.mask0 = pwdata[7:0];
         end else if (idx == IDX_MASK1) begin
            next_cur.mask1 = pwdata[7:0] & MASK1_USED;
         end else if (idx == IDX_MASK2) begin
            next_cur.mask2 = pwdata[7:0];
         end else if (idx == IDX_CTRL) begin
            next_cur.gie = pwdata[CTRL_GIE_BIT];
            next_cur.sleep = pwdata[CTRL_SLEEP_BIT];
         end
      end
      // flags: set beats clear when both land in one cycle
      for (int c = 0; c < NUM_EXT; c++) begin
         next_cur.extFlag[c] = (cur.extFlag[c] & ~irqAck[IRQ_EXT0 + c]
            & ~(w1c & idx == IDX_EXT_FLAGS & pwdata[c])) | extEvent[c];
         if (cur.sense[c*2 +: 2] == SENSE_LOW) begin
            next_cur.extFlag[c] = 1'b0;
         end
      end
      for (int g = 0; g < NUM_GRP; g++) begin
         next_cur.pcFlag[g] = (cur.pcFlag[g] & ~irqAck[IRQ_GRP0 + g]
            & ~(w1c & idx == IDX_PC_FLAGS & pwdata[g])) | pcEvent[g];
      end
      // requests toward the core
      for (int c = 0; c < NUM_EXT; c++) begin
         // a level gone before wake-up completes leaves no request behind
         next_cur.irq[IRQ_EXT0 + c] = cur.gie & cur.extEn[c]
            & ((levelLow[c] & ~stopped) | flagSeen[c]);
      end
      for (int g = 0; g < NUM_GRP; g++) begin
         next_cur.irq[IRQ_GRP0 + g] = cur.gie & cur.pcEn[g] & cur.pcFlag[g];
      end
      next_cur.wake = stopped & ((|(cur.extEn & levelLow)) | (|(cur.pcEn & cur.pcFlag)));
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign irqReq = cur.irq;
   assign wakeReq = cur.wake;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_level_flag_zero;
      cur.sense[1:0] == SENSE_LOW |=> !cur.extFlag[0];
   endproperty
   a_level_flag_zero: assert property (p_level_flag_zero) else $error("flag set in level mode");

   property p_rise_sets_flag;
      (cur.sense[3:2] == SENSE_RISE && !stopped && cur.syncB[1] && !cur.last[1])
         |=> cur.extFlag[1];
   endproperty
   a_rise_sets_flag: assert property (p_rise_sets_flag) else $error("rising edge missed");

   property p_ext_req_gated;
      irqReq[IRQ_EXT0] |-> $past(cur.gie) && $past(cur.extEn[0]);
   endproperty
   a_ext_req_gated: assert property (p_ext_req_gated) else $error("ungated channel request");

   property p_grp_req_gated;
      irqReq[IRQ_GRP0] |-> $past(cur.gie) && $past(cur.pcEn[0]);
   endproperty
   a_grp_req_gated: assert property (p_grp_req_gated) else $error("ungated group request");

   property p_grp_flag_set;
      pcEvent[2] |=> cur.pcFlag[2];
   endproperty
   a_grp_flag_set: assert property (p_grp_flag_set) else $error("group flag not set");

   property p_sleep_no_edge;
      (stopped && !cur.extFlag[0]) |=> !cur.extFlag[0];
   endproperty
   a_sleep_no_edge: assert property (p_sleep_no_edge) else $error("edge seen in sleep");

   property p_ack_clears;
      (irqAck[IRQ_EXT0] && !extEvent[0]) |=> !cur.extFlag[0];
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("flag survived ack");

   property p_level_request;
      (cur.gie && cur.extEn[0] && levelLow[0] && !stopped) |=> irqReq[IRQ_EXT0];
   endproperty
   a_level_request: assert property (p_level_request) else $error("level not requested");

   property p_level_wake;
      (stopped && cur.extEn[0] && levelLow[0]) |=> wakeReq && !irqReq[IRQ_EXT0];
   endproperty
   a_level_wake: assert property (p_level_wake) else $error("level wake wrong");

   property p_rd_upper_zero;
      pready |-> prdata[31:8] == 24'h000000;
   endproperty
   a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("upper bits nonzero");

   // ****************************************
   // channel checks
   // ****************************************
   property p_level_flag_zero_ch1;
      cur.sense[3:2] == SENSE_LOW |=> !cur.extFlag[1];
   endproperty
   a_level_flag_zero_ch1: assert property (p_level_flag_zero_ch1) else $error("flag set in level mode");

   property p_fall_sets_flag;
      (cur.sense[1:0] == SENSE_FALL && !stopped && !cur.syncB[0] && cur.last[0]) |=> cur.extFlag[0];
   endproperty
   a_fall_sets_flag: assert property (p_fall_sets_flag) else $error("falling edge missed");

   property p_any_sets_flag;
      (cur.sense[1:0] == SENSE_ANY && !stopped && cur.syncB[0] != cur.last[0]) |=> cur.extFlag[0];
   endproperty
   a_any_sets_flag: assert property (p_any_sets_flag) else $error("change missed");

   property p_rise_only;
      (cur.sense[1:0] == SENSE_RISE && !cur.extFlag[0] && !(cur.syncB[0] && !cur.last[0])) |=> !cur.extFlag[0];
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("flag without rising edge");

   property p_sleep_no_edge_ch1;
      (stopped && !cur.extFlag[1]) |=> !cur.extFlag[1];
   endproperty
   a_sleep_no_edge_ch1: assert property (p_sleep_no_edge_ch1) else $error("edge seen in sleep");

   property p_w1c_clears;
      (w1c && idx == IDX_EXT_FLAGS && pwdata[0] && !extEvent[0]) |=> !cur.extFlag[0];
   endproperty
   a_w1c_clears: assert property (p_w1c_clears) else $error("flag survived write one");

   property p_w1c_clears_ch1;
      (w1c && idx == IDX_EXT_FLAGS && pwdata[1] && !extEvent[1]) |=> !cur.extFlag[1];
   endproperty
   a_w1c_clears_ch1: assert property (p_w1c_clears_ch1) else $error("flag survived write one");

   property p_ext1_req_gated;
      irqReq[IRQ_EXT1] |-> $past(cur.gie) && $past(cur.extEn[1]);
   endproperty
   a_ext1_req_gated: assert property (p_ext1_req_gated) else $error("ungated channel request");

   property p_edge_request;
      (cur.gie && cur.extEn[0] && cur.extFlag[0] && cur.sense[1:0] != SENSE_LOW) |=> irqReq[IRQ_EXT0];
   endproperty
   a_edge_request: assert property (p_edge_request) else $error("edge not requested");

   property p_no_wake_awake;
      !stopped |=> !wakeReq;
   endproperty
   a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake while running");

   // ****************************************
   // group checks
   // ****************************************
   property p_grp_flag_set0;
      pcEvent[0] |=> cur.pcFlag[0];
   endproperty
   a_grp_flag_set0: assert property (p_grp_flag_set0) else $error("group flag not set");

   property p_grp_flag_set1;
      pcEvent[1] |=> cur.pcFlag[1];
   endproperty
   a_grp_flag_set1: assert property (p_grp_flag_set1) else $error("group flag not set");

   property p_grp_quiet0;
      (cur.syncB[NUM_EXT +: 8] == cur.last[NUM_EXT +: 8]) |-> !pcEvent[0];
   endproperty
   a_grp_quiet0: assert property (p_grp_quiet0) else $error("group event without toggle");

   property p_grp_quiet1;
      (cur.syncB[NUM_EXT + 8 +: 7] == cur.last[NUM_EXT + 8 +: 7]) |-> !pcEvent[1];
   endproperty
   a_grp_quiet1: assert property (p_grp_quiet1) else $error("group event without toggle");

   property p_grp_req_gated2;
      irqReq[IRQ_GRP0 + 2] |-> $past(cur.gie) && $past(cur.pcEn[2]);
   endproperty
   a_grp_req_gated2: assert property (p_grp_req_gated2) else $error("ungated group request");

   property p_grp_w1c;
      (w1c && idx == IDX_PC_FLAGS && pwdata[0] && !pcEvent[0]) |=> !cur.pcFlag[0];
   endproperty
   a_grp_w1c: assert property (p_grp_w1c) else $error("group flag survived write one");

   property p_grp_w1c2;
      (w1c && idx == IDX_PC_FLAGS && pwdata[2] && !pcEvent[2]) |=> !cur.pcFlag[2];
   endproperty
   a_grp_w1c2: assert property (p_grp_w1c2) else $error("group flag survived write one");

   property p_grp_req_follows;
      (cur.gie && cur.pcEn[1] && cur.pcFlag[1]) |=> irqReq[IRQ_GRP0 + 1];
   endproperty
   a_grp_req_follows: assert property (p_grp_req_follows) else $error("group not requested");

   // ****************************************
   // bus and pipeline checks
   // ****************************************
   property p_rd_err_zero;
      (pready && pslverr) |-> prdata == 32'h00000000;
   endproperty
   a_rd_err_zero: assert property (p_rd_err_zero) else $error("unmapped read nonzero");

   property p_sync_order;
      cur.syncB == $past(cur.syncA) && cur.last == $past(cur.syncB);
   endproperty
   a_sync_order: assert property (p_sync_order) else $error("sample chain skipped");

   property p_mask1_top;
      !cur.mask1[7];
   endproperty
   a_mask1_top: assert property (p_mask1_top) else $error("unused mask bit set");

   c_ext_irq: cover property (extEvent[0] ##1 cur.extFlag[0] ##1 irqReq[IRQ_EXT0]);
   c_level_irq: cover property (levelLow[0] && !stopped ##1 irqReq[IRQ_EXT0]);
   c_unmapped: cover property (pready && pslverr);
   c_grp2_irq: cover property (pcEvent[2] ##2 irqReq[IRQ_GRP0 + 2]);
   c_wake: cover property (stopped ##1 wakeReq);
endmodule : epiu_top
`default_nettype wire

// file: src/epiu_pkg.sv
// constants and state type of the external pin interrupt unit
package epiu_pkg;
   // ****************************************
   // register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [9:0] IDX_PC_FLAGS = 10'h03b;
   localparam logic [9:0] IDX_EXT_FLAGS = 10'h03c;
   localparam logic [9:0] IDX_EXT_EN = 10'h03d;
   localparam logic [9:0] IDX_PC_EN = 10'h068;
   localparam logic [9:0] IDX_SENSE = 10'h069;
   localparam logic [9:0] IDX_MASK0 = 10'h06b;
   localparam logic [9:0] IDX_MASK1 = 10'h06c;
   localparam logic [9:0] IDX_MASK2 = 10'h06d;
   localparam logic [9:0] IDX_CTRL = 10'h070;
   // ****************************************
   // fields, codes, reset values
   // ****************************************
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int NUM_EXT = 2;
   localparam int NUM_GRP = 3;
   localparam int NUM_PC = 24;
   localparam int NUM_PINS = NUM_EXT + NUM_PC;
   localparam logic [7:0] MASK1_USED = 8'h7f;
   localparam logic [7:0] REG_RESET = 8'h00;
   // request vector order
   localparam int IRQ_EXT0 = 0;
   localparam int IRQ_EXT1 = 1;
   localparam int IRQ_GRP0 = 2;
   localparam int NUM_IRQ = 5;

   typedef struct packed {
      logic [NUM_PINS-1:0] syncA;
      logic [NUM_PINS-1:0] syncB;
      logic [NUM_PINS-1:0] last;
      logic [3:0] sense;
      logic [1:0] extEn;
      logic [1:0] extFlag;
      logic [2:0] pcEn;
      logic [2:0] pcFlag;
      logic [7:0] mask0;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic gie;
      logic sleep;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [NUM_IRQ-1:0] irq;
      logic wake;
   } epiu_state_t;
endpackage : epiu_pkg

// file: tb/epiu_pin_drv.sv
// model of the outside circuitry that drives the interrupt pins
`timescale 1ns/10ps
`default_nettype none
module epiu_pin_drv (
   // clock
   input wire logic clk,
   // requested levels {one, zero, pin-change}
   input wire logic [25:0] want,
   // pins
   output logic pin0,
   output logic pin1,
   output logic [23:0] pcPins
);
   initial {pin1, pin0, pcPins} = 26'h0;
   // levels move only after an edge and then stand; a low level is held until released
   always @(posedge clk) begin
      {pin1, pin0, pcPins} <= want;
   end
endmodule : epiu_pin_drv
`default_nettype wire

// file: tb/epiu_top_test.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
`default_nettype none
module epiu_top_test;
   import epiu_pkg::*;
   typedef struct {logic [9:0] idx; logic [7:0] wd; logic [7:0] exp; logic err;} epiu_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] irqAck = 5'h0;
   logic [4:0] irqReq;
   logic wakeReq;
   logic [25:0] want = 26'h0;
   logic [25:0] lv = 26'h0;
   logic pin0;
   logic pin1;
   logic [23:0] pcPins;
   int nErrors = 0;
   int numChecks = 0;
   epiu_row_t rows [9] = '{'{IDX_SENSE, 8'hff, 8'h0f, 1'b0}, '{IDX_EXT_EN, 8'hff, 8'h03, 1'b0},
      '{IDX_PC_EN, 8'hff, 8'h07, 1'b0}, '{IDX_MASK0, 8'ha5, 8'ha5, 1'b0},
      '{IDX_MASK1, 8'hff, 8'h7f, 1'b0}, '{IDX_MASK2, 8'h5a, 8'h5a, 1'b0},
      '{IDX_EXT_FLAGS, 8'h00, 8'h00, 1'b0}, '{IDX_PC_FLAGS, 8'h00, 8'h00, 1'b0},
      '{10'h3ff, 8'h00, 8'h00, 1'b1}};
   int pos [3] = '{0, 8, 17};

   always #5 clk = ~clk;

   epiu_pin_drv pinDrv (.clk(clk), .want(want), .pin0(pin0), .pin1(pin1), .pcPins(pcPins));
   epiu_top DUT (.clk(clk), .sys_rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
      .pin_change_inputs(pcPins), .irqAck(irqAck), .irqReq(irqReq), .wakeReq(wakeReq));

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // called just after a rising edge; pready read right after each edge, before it updates
   task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) nErrors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle keeps a following call from driving psel twice in a step
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      logic e;
      apb(idx, 1'b1, wd, d, e);
   endtask : wr

   task automatic rdChk(input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic e;
      apb(idx, 1'b0, 8'h0, d, e);
      chk(d, {24'h0, exp});
   endtask : rdChk

   // flag latency is a few edges; eight leaves margin
   task automatic flip(input logic [25:0] x);
      lv = lv ^ x;
      want <= lv;
      repeat (8) @(posedge clk);
   endtask : flip

   task automatic outChk(input logic [5:0] exp);
      @(negedge clk);
      chk({26'h0, wakeReq, irqReq}, {26'h0, exp});
      @(posedge clk);
   endtask : outChk

   task automatic testDone();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : testDone

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      logic [31:0] d;
      logic e;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         rdChk(rows[i].idx, 8'h00);
         wr(rows[i].idx, rows[i].wd);
         apb(rows[i].idx, 1'b0, 8'h0, d, e);
         chk(d, {24'h0, rows[i].exp});
         chk({31'h0, e}, {31'h0, rows[i].err});
      end
      pstrb <= 4'h0;
      wr(IDX_MASK0, 8'h00);
      pstrb <= 4'hf;
      rdChk(IDX_MASK0, 8'ha5);
      wr(IDX_CTRL, 8'h01);
      for (int c = 1; c < 4; c++) begin
         wr(IDX_SENSE, {4'h0, 2'h3, c[1:0]});
         flip(26'h1000000);
         rdChk(IDX_EXT_FLAGS, {7'h0, c != 2});
         wr(IDX_EXT_FLAGS, 8'h01);
         flip(26'h1000000);
         rdChk(IDX_EXT_FLAGS, {7'h0, c != 3});
         wr(IDX_EXT_FLAGS, 8'h01);
      end
      flip(26'h1000000);
      outChk(6'h01);
      irqAck <= 5'h01;
      @(posedge clk);
      irqAck <= 5'h00;
      rdChk(IDX_EXT_FLAGS, 8'h00);
      outChk(6'h00);
      wr(IDX_CTRL, 8'h00);
      flip(26'h2000000);
      outChk(6'h00);
      rdChk(IDX_EXT_FLAGS, 8'h02);
      wr(IDX_EXT_FLAGS, 8'h02);
      rdChk(IDX_EXT_FLAGS, 8'h00);
      wr(IDX_CTRL, 8'h01);
      wr(IDX_SENSE, 8'h0c);
      flip(26'h1000000);
      outChk(6'h01);
      rdChk(IDX_EXT_FLAGS, 8'h00);
      flip(26'h1000000);
      outChk(6'h00);
      for (int g = 0; g < 3; g++) begin
         flip(26'h1 << pos[g]);
         rdChk(IDX_PC_FLAGS, 8'h1 << g);
         outChk(6'h4 << g);
         wr(IDX_PC_FLAGS, 8'h1 << g);
         rdChk(IDX_PC_FLAGS, 8'h00);
      end
      flip(26'h0018002);
      rdChk(IDX_PC_FLAGS, 8'h00);
      wr(IDX_CTRL, 8'h03);
      flip(26'h1000000);
      outChk(6'h20);
      flip(26'h1000000);
      wr(IDX_CTRL, 8'h01);
      outChk(6'h00);
      wr(IDX_SENSE, 8'h0b);
      wr(IDX_CTRL, 8'h03);
      flip(26'h2000000);
      rdChk(IDX_EXT_FLAGS, 8'h00);
      flip(26'h0000001);
      rdChk(IDX_PC_FLAGS, 8'h01);
      outChk(6'h24);
      // mid-run reset: registers and outputs back to zero
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      outChk(6'h00);
      rdChk(IDX_MASK2, 8'h00);
      rdChk(IDX_PC_FLAGS, 8'h00);
      testDone();
   end

   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      testDone();
   end
endmodule : epiu_top_test
`default_nettype wire
